// file: pkg/wl_cfg.svh
// offsets, field positions, reset values and timing counts of the leveling controller
`ifndef WL_CFG_SVH
`define WL_CFG_SVH
// ************************************
// mode register one fields
// ************************************
`define MR_W         14
`define LVL_BIT      7
`define QOFF_BIT     12
// ************************************
// register map
// ************************************
`define OFF_CTRL     8'h00
`define OFF_MR1      8'h04
`define OFF_GAP      8'h08
`define OFF_STAT     8'h0C
`define OFF_DLY      8'h10
`define CTRL_START   0
`define CTRL_DLL_OFF 1
`define CTRL_LAT_UP  2
`define CTRL_RANK    4
`define STAT_BUSY    0
`define STAT_DONE    1
`define STAT_FAIL    2
`define STAT_LOCK    8
`define STAT_MISM    16
`define MR1_RST      14'h0000
`define GAP_RST      16'h0010
// ************************************
// timing counts in clk cycles, then the delay setting width
// ************************************
`define T_MOD_CYC    24
`define T_MRD_CYC    8
`define T_ODTON_CYC  10
`define T_ODTOFF_CYC 10
`define T_ADC_CYC    4
`define T_AONAS_CYC  4
`define T_DQSL_CYC   2
`define T_DQSH_CYC   2
`define T_WLMRD_CYC  40
`define T_WLO_CYC    1
`define T_WLOE_CYC   1
`define SYNC_CYC     2
`define CK_HALF_CYC  2
`define DLY_W        6
`endif

// file: pkg/wl_pkg.sv
// types of the leveling controller
`include "wl_cfg.svh"
package wl_pkg;
  typedef logic [`MR_W-1:0] mr_value_t;
  typedef enum logic [3:0] {
    S_IDLE, S_QOFF, S_ENTER, S_WMOD, S_WDQSEN, S_LOW, S_HIGH, S_TAIL,
    S_WFB, S_EVAL, S_GAP, S_STOP, S_WOFF, S_EXIT, S_XMOD, S_REST
  } wl_state_e;
endpackage

// file: rtl/wl_ctrl.sv
// write leveling controller: apb registers, dram pin sequencer, per lane search
// ************************************
// ************************************
//
// The address map and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "wl_cfg.svh"
module wl_ctrl #(
  parameter int RANKS   = 2,
  parameter int LANES   = 2,
  parameter int LANE_W  = 8,
  parameter int DW      = `DLY_W,
  parameter int T_MOD   = `T_MOD_CYC,
  parameter int T_MRD   = `T_MRD_CYC,
  parameter int T_ODTON = `T_ODTON_CYC,
  parameter int T_ODTOF = `T_ODTOFF_CYC,
  parameter int T_ADC   = `T_ADC_CYC,
  parameter int T_AONAS = `T_AONAS_CYC,
  parameter int T_DQSL  = `T_DQSL_CYC,
  parameter int T_DQSH  = `T_DQSH_CYC,
  parameter int T_WLMRD = `T_WLMRD_CYC,
  parameter int T_WLO   = `T_WLO_CYC,
  parameter int T_WLOE  = `T_WLOE_CYC,
  parameter int CK_HALF = `CK_HALF_CYC,
  parameter int RW      = $clog2(RANKS + 1)
) (
  input  wire logic                    clk,
  input  wire logic                    reset,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [7:0]              paddr,
  input  wire logic [31:0]             pwdata,
  output logic      [31:0]             prdata,
  output logic                         pready,
  output logic                         pslverr,
  output logic                         ck_t,
  output logic                         ck_c,
  output logic                         mrs_strobe,
  output logic      [RW-1:0]           mrs_rank,
  output wl_pkg::mr_value_t            mrs_value,
  output logic                         termination_control_pin,
  output logic                         dqs_t,
  output logic                         dqs_c,
  output logic                         dqs_oe,
  input  wire logic [LANES*LANE_W-1:0] dq_in,
  output logic      [LANES*DW-1:0]     dqs_delay
);
  import wl_pkg::*;

  localparam int FIRST = (T_WLMRD > T_DQSL) ? T_WLMRD : T_DQSL;
  localparam int T_FB  = T_WLO + T_WLOE + `SYNC_CYC;
  localparam int MAXR  = RANKS;

  wl_state_e           state_q, state_d;
  logic [15:0]         tmr_q, tmr_d, since_q, hi_cnt_q, lo_cnt_q, gap_q;
  logic [RW-1:0]       ridx_q, ridx_d, rank_q, iss_rank;
  logic [7:0]          ck_cnt_q;
  mr_value_t           mr1_q, iss_val;
  logic                issue, eval, fin, ovf_hit;
  logic                start_q, dll_off_q, lat_up_q, done_q, fail_q, first_q;
  logic                wr, hit;
  logic [31:0]         rdata;
  logic [LANES*LANE_W-1:0] fb_s;
  logic [LANES-1:0]    lock_v, ovf_v, mism_v;
  logic [15:0]         mod_wait, dqsen_wait;

  // ************************************
  // apb slave, one wait state per access
  // ************************************
  assign wr = psel && penable && pready && pwrite && !pslverr;

  always_comb begin
    hit   = 1'b1;
    rdata = 32'h0000_0000;
    case (paddr)
      `OFF_CTRL: rdata = 32'({rank_q, 1'b0, lat_up_q, dll_off_q, 1'b0});
      `OFF_MR1:  rdata = 32'(mr1_q);
      `OFF_GAP:  rdata = 32'(gap_q);
      `OFF_STAT: rdata = 32'({mism_v, 8'(lock_v), 5'h00, fail_q, done_q,
                             state_q != S_IDLE});
      `OFF_DLY:  rdata = 32'(dqs_delay);
      default:   hit = 1'b0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else if (psel && penable && !pready) begin
      pready  <= 1'b1;
      pslverr <= !hit;
      prdata  <= rdata;
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // settings change only while idle so a running search sees one setup
  always_ff @(posedge clk) begin
    if (reset) begin
      start_q   <= 1'b0;
      dll_off_q <= 1'b0;
      lat_up_q  <= 1'b0;
      rank_q    <= '0;
      mr1_q     <= `MR1_RST;
      gap_q     <= `GAP_RST;
    end else begin
      start_q <= 1'b0;
      if (wr && state_q == S_IDLE) begin
        case (paddr)
          `OFF_CTRL: begin
            start_q   <= pwdata[`CTRL_START];
            dll_off_q <= pwdata[`CTRL_DLL_OFF];
            lat_up_q  <= pwdata[`CTRL_LAT_UP];
            rank_q    <= pwdata[`CTRL_RANK +: RW];
          end
          `OFF_MR1: mr1_q <= pwdata[`MR_W-1:0];
          `OFF_GAP: gap_q <= pwdata[15:0];
          default: ;
        endcase
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      done_q <= 1'b0;
      fail_q <= 1'b0;
    end else if (start_q) begin
      done_q <= 1'b0;
      fail_q <= 1'b0;
    end else begin
      if (fin) done_q <= 1'b1;
      if (ovf_hit) fail_q <= 1'b1;
    end
  end

  // ************************************
  // leveling sequencer
  // ************************************
  assign mod_wait   = lat_up_q ? 16'(T_MOD + T_ODTON) : 16'(T_MOD);
  assign dqsen_wait = dll_off_q ? 16'(T_AONAS + 1) : 16'(T_ODTON + T_ADC + 1);

  always_comb begin
    state_d  = state_q;
    tmr_d    = (tmr_q != 16'h0000) ? tmr_q - 16'h0001 : 16'h0000;
    ridx_d   = ridx_q;
    issue    = 1'b0;
    iss_rank = rank_q;
    iss_val  = mr1_q;
    eval     = 1'b0;
    fin      = 1'b0;
    ovf_hit  = 1'b0;
    case (state_q)
      S_IDLE: begin
        if (start_q) begin
          ridx_d  = '0;
          state_d = S_QOFF;
        end
      end
      S_QOFF, S_REST: begin
        iss_rank = ridx_q;
        iss_val[`LVL_BIT] = 1'b0;
        iss_val[`QOFF_BIT] = (state_q == S_QOFF) ? 1'b1 : mr1_q[`QOFF_BIT];
        if (tmr_q == 16'h0000) begin
          if (ridx_q == RW'(MAXR)) begin
            state_d = (state_q == S_QOFF) ? S_ENTER : S_IDLE;
            fin     = (state_q == S_REST);
          end else begin
            if (ridx_q != rank_q) begin
              issue = 1'b1;
              tmr_d = 16'(T_MRD - 1);
            end
            ridx_d = ridx_q + 1'b1;
          end
        end
      end
      S_ENTER: begin
        issue = 1'b1;
        iss_val[`LVL_BIT]  = 1'b1;
        iss_val[`QOFF_BIT] = 1'b0;
        tmr_d   = mod_wait - 16'h0001;
        state_d = S_WMOD;
      end
      S_WMOD: begin
        // data pins are ignored here: they are undefined until feedback
        if (tmr_q == 16'h0000) begin
          tmr_d   = dqsen_wait - 16'h0001;
          state_d = S_WDQSEN;
        end
      end
      S_WDQSEN: begin
        if (tmr_q == 16'h0000) begin
          tmr_d   = 16'(FIRST - 1);
          state_d = S_LOW;
        end
      end
      S_LOW: begin
        if (tmr_q == 16'h0000) begin
          tmr_d   = 16'(T_DQSH - 1);
          state_d = S_HIGH;
        end
      end
      S_HIGH: begin
        if (tmr_q == 16'h0000) begin
          tmr_d   = 16'(T_DQSL - 1);
          state_d = S_TAIL;
        end
      end
      S_TAIL: begin
        if (tmr_q == 16'h0000) begin
          tmr_d   = 16'(T_FB - 1);
          state_d = S_WFB;
        end
      end
      S_WFB: begin
        if (tmr_q == 16'h0000) state_d = S_EVAL;
      end
      S_EVAL: begin
        eval    = 1'b1;
        tmr_d   = gap_q;
        state_d = S_GAP;
      end
      S_GAP: begin
        if (tmr_q == 16'h0000) begin
          if ((&lock_v) || (|ovf_v)) begin
            ovf_hit = |ovf_v;
            state_d = S_STOP;
          end else begin
            tmr_d   = 16'(T_DQSL - 1);
            state_d = S_LOW;
          end
        end
      end
      S_STOP: begin
        tmr_d   = 16'(T_ODTOF - 1);
        state_d = S_WOFF;
      end
      S_WOFF: begin
        if (tmr_q == 16'h0000) state_d = S_EXIT;
      end
      S_EXIT: begin
        issue = 1'b1;
        iss_val[`LVL_BIT] = 1'b0;
        tmr_d   = 16'(T_MOD - 1);
        state_d = S_XMOD;
      end
      S_XMOD: begin
        if (tmr_q == 16'h0000) begin
          ridx_d  = '0;
          state_d = S_REST;
        end
      end
      default: state_d = S_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state_q <= S_IDLE;
      tmr_q   <= 16'h0000;
      ridx_q  <= '0;
    end else begin
      state_q <= state_d;
      tmr_q   <= tmr_d;
      ridx_q  <= ridx_d;
    end
  end

  // ************************************
  // dram pins
  // ************************************
  // only mr1 writes ever leave here; all other cycles are deselects
  always_ff @(posedge clk) begin
    if (reset) begin
      mrs_strobe <= 1'b0;
      mrs_rank   <= '0;
      mrs_value  <= '0;
    end else begin
      mrs_strobe <= issue;
      if (issue) begin
        mrs_rank  <= iss_rank;
        mrs_value <= iss_val;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      termination_control_pin    <= 1'b0;
      dqs_oe <= 1'b0;
      dqs_t  <= 1'b0;
      dqs_c  <= 1'b1;
    end else begin
      termination_control_pin    <= state_d inside {S_WDQSEN, S_LOW, S_HIGH, S_TAIL, S_WFB, S_EVAL, S_GAP};
      dqs_oe <= state_d inside {S_LOW, S_HIGH, S_TAIL, S_WFB, S_EVAL, S_GAP};
      dqs_t  <= (state_d == S_HIGH);
      dqs_c  <= (state_d != S_HIGH);
    end
  end

  // the memory clock is a plain divide of clk; strobe phase comes from the delay line
  always_ff @(posedge clk) begin
    if (reset) begin
      ck_cnt_q <= 8'h00;
      ck_t     <= 1'b0;
      ck_c     <= 1'b1;
    end else if (ck_cnt_q == 8'(CK_HALF - 1)) begin
      ck_cnt_q <= 8'h00;
      ck_t     <= !ck_t;
      ck_c     <= ck_t;
    end else begin
      ck_cnt_q <= ck_cnt_q + 8'h01;
    end
  end

  // ************************************
  // feedback per byte lane
  // ************************************
  wl_sync2 #(.W(LANES*LANE_W)) u_sync (
    .clk   (clk),
    .reset (reset),
    .din   (dq_in),
    .dout  (fb_s)
  );

  for (genvar g = 0; g < LANES; g++) begin : g_lane
    wl_lane #(.LW(LANE_W), .DW(DW)) u_lane (
      .clk      (clk),
      .reset    (reset),
      .clear    (start_q),
      .eval     (eval),
      .fb       (fb_s[g*LANE_W +: LANE_W]),
      .dly_q    (dqs_delay[g*DW +: DW]),
      .locked_q (lock_v[g]),
      .ovf_q    (ovf_v[g]),
      .mism_q   (mism_v[g])
    );
  end

  // ************************************
  // check helpers
  // ************************************
  always_ff @(posedge clk) begin
    if (reset) begin
      since_q  <= 16'h0000;
      hi_cnt_q <= 16'h0000;
      lo_cnt_q <= 16'h0000;
      first_q  <= 1'b0;
    end else begin
      since_q  <= (state_q == S_ENTER) ? 16'h0000 : since_q + 16'(!(&since_q));
      hi_cnt_q <= dqs_t ? hi_cnt_q + 16'h0001 : 16'h0000;
      lo_cnt_q <= (dqs_oe && !dqs_t) ? lo_cnt_q + 16'h0001 : 16'h0000;
      first_q  <= (state_q == S_ENTER) ? 1'b1 : (first_q && !dqs_t);
    end
  end

  sequence s_enter_cmd;
    mrs_strobe && mrs_value[`LVL_BIT] && !mrs_value[`QOFF_BIT];
  endsequence
  sequence s_edge_done;
    $fell(dqs_t) ##[1:40] (state_q == S_EVAL);
  endsequence

  a_enter_cmd: assert property (@(posedge clk) disable iff (reset)
    state_q == S_ENTER |=> s_enter_cmd and mrs_rank == rank_q)
    else $error("entry write missing or wrong");
  a_exit_cmd: assert property (@(posedge clk) disable iff (reset)
    state_q == S_EXIT |=> mrs_strobe && !mrs_value[`LVL_BIT]
      && mrs_value[`QOFF_BIT] == mr1_q[`QOFF_BIT])
    else $error("exit write missing or wrong");
  a_others_off: assert property (@(posedge clk) disable iff (reset)
    mrs_strobe && $past(state_q) == S_QOFF |-> mrs_value[`QOFF_BIT] && mrs_rank != rank_q)
    else $error("other rank not set output-off");
  a_odt_after_mod: assert property (@(posedge clk) disable iff (reset)
    $rose(termination_control_pin) |-> since_q >= (lat_up_q ? 16'(T_MOD + T_ODTON) : 16'(T_MOD)))
    else $error("termination raised too early");
  a_dqs_enable: assert property (@(posedge clk) disable iff (reset)
    $rose(dqs_oe) |-> !dqs_t && dqs_c && termination_control_pin && since_q > (dll_off_q
      ? 16'(T_MOD + T_AONAS) : 16'(T_MOD + T_ODTON + T_ADC)))
    else $error("strobe driven before enable delay");
  a_strobe_high: assert property (@(posedge clk) disable iff (reset)
    $fell(dqs_t) |-> hi_cnt_q >= 16'(T_DQSH))
    else $error("strobe high too short");
  a_strobe_low: assert property (@(posedge clk) disable iff (reset)
    $rose(dqs_t) |-> lo_cnt_q >= (first_q ? 16'(FIRST) : 16'(T_DQSL)))
    else $error("strobe low too short before edge");
  a_fb_sampled: assert property (@(posedge clk) disable iff (reset)
    $fell(dqs_t) && dqs_oe |-> s_edge_done)
    else $error("feedback not sampled after edge");
  a_exit_order: assert property (@(posedge clk) disable iff (reset)
    state_q == S_EXIT |-> !termination_control_pin && !dqs_oe && $past(!termination_control_pin, 2))
    else $error("exit before strobes and termination off");
  a_only_mrs: assert property (@(posedge clk) disable iff (reset)
    mrs_strobe && first_q |-> $past(state_q) inside {S_ENTER, S_EXIT})
    else $error("illegal command while leveling");
endmodule

// file: rtl/wl_lane.sv
// per byte lane strobe delay search and lock
`timescale 1ns/1ps
`include "wl_cfg.svh"
module wl_lane #(
  parameter int LW = 8,
  parameter int DW = `DLY_W
) (
  input  wire logic          clk,
  input  wire logic          reset,
  input  wire logic          clear,
  input  wire logic          eval,
  input  wire logic [LW-1:0] fb,
  output logic      [DW-1:0] dly_q,
  output logic               locked_q,
  output logic               ovf_q,
  output logic               mism_q
);
  logic prev_q;
  logic seen_q;
  logic bit_now;
  logic rise;

  // one bit decides; lanes with disagreeing bits are flagged, not trusted more
  assign bit_now = fb[0];
  assign rise    = seen_q && !prev_q && bit_now;

  always_ff @(posedge clk) begin
    if (reset || clear) begin
      dly_q    <= '0;
      locked_q <= 1'b0;
      ovf_q    <= 1'b0;
      mism_q   <= 1'b0;
      prev_q   <= 1'b0;
      seen_q   <= 1'b0;
    end else if (eval && !locked_q && !ovf_q) begin
      prev_q <= bit_now;
      seen_q <= 1'b1;
      if (!((&fb) || !(|fb))) begin
        mism_q <= 1'b1;
      end
      if (rise) begin
        locked_q <= 1'b1;
      end else if (&dly_q) begin
        ovf_q <= 1'b1;
      end else begin
        dly_q <= dly_q + 1'b1;
      end
    end
  end

  a_lock_on_rise: assert property (@(posedge clk) disable iff (reset)
    eval && !locked_q && !ovf_q && rise && !clear |=> locked_q && $stable(dly_q))
    else $error("lane did not lock on 0-to-1 feedback");
  a_step_delay: assert property (@(posedge clk) disable iff (reset)
    eval && !locked_q && !ovf_q && !rise && !(&dly_q) && !clear
    |=> dly_q == $past(dly_q) + 1'b1)
    else $error("lane delay not stepped after feedback");
endmodule

// file: rtl/wl_sync2.sv
// two-flop synchroniser for asynchronous pin inputs
`timescale 1ns/1ps
module wl_sync2 #(
  parameter int W = 8
) (
  input  wire logic         clk,
  input  wire logic         reset,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] meta_q;

  always_ff @(posedge clk) begin
    if (reset) begin
      meta_q <= '0;
      dout   <= '0;
    end else begin
      meta_q <= din;
      dout   <= meta_q;
    end
  end
endmodule

// file: test/wl_ctrl_test.sv
// testbench of the write leveling controller
`timescale 1ns/1ps
`include "wl_cfg.svh"
module wl_ctrl_test;
  import wl_pkg::*;
  // ************************************
  // signals
  // ************************************
  logic        clk, reset, psel, penable, pwrite, pready, pslverr, slv, bad_bit;
  logic        ck_t, ck_c, mrs_strobe, termination_control_pin, dqs_t, dqs_c, dqs_oe, ck0;
  logic [7:0]  paddr, viol;
  logic [31:0] pwdata, prdata, rd;
  logic [1:0]  mrs_rank;
  mr_value_t   mrs_value;
  logic [15:0] dq, odt_min, oe_min;
  logic [11:0] dqs_delay, thr;
  logic [27:0] mr1;
  int          err_total, n_tests;
  wl_ctrl uut (.clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ck_t(ck_t), .ck_c(ck_c), .mrs_strobe(mrs_strobe), .mrs_rank(mrs_rank),
    .mrs_value(mrs_value), .termination_control_pin(termination_control_pin), .dqs_t(dqs_t), .dqs_c(dqs_c), .dqs_oe(dqs_oe),
    .dq_in(dq), .dqs_delay(dqs_delay));
  wl_dram_model dram (.clk(clk), .mrs_strobe(mrs_strobe), .mrs_rank(mrs_rank),
    .mrs_value(mrs_value), .termination_control_pin(termination_control_pin), .dqs_t(dqs_t), .dqs_c(dqs_c), .dqs_oe(dqs_oe),
    .dqs_delay(dqs_delay), .thr(thr), .bad_bit(bad_bit), .odt_min(odt_min),
    .oe_min(oe_min), .dq(dq), .mr1(mr1), .viol(viol));
  // ************************************
  // tasks
  // ************************************
  task automatic print_verdict;
    if (err_total == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // one apb transfer; waits on pready with no assumed latency
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) chk("pready", 1, 0);
    rd = prdata;
    slv = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge clk);
  endtask
  // one leveling pass on rank rk; polls status until busy clears
  task automatic run(input logic rk, input logic dll, input logic lat, input logic [11:0] t,
                     input logic bad, input logic busy_wr);
    int k;
    k = 0;
    thr <= t;
    bad_bit <= bad;
    odt_min <= 16'(`T_MOD_CYC + (lat ? `T_ODTON_CYC : 0));
    oe_min <= 16'(`T_MOD_CYC + (lat ? `T_ODTON_CYC : 0)
                  + (dll ? `T_AONAS_CYC : `T_ODTON_CYC + `T_ADC_CYC));
    apb(1, `OFF_CTRL, {26'h0, 1'b0, rk, 1'b0, lat, dll, 1'b1});
    if (busy_wr) apb(1, `OFF_GAP, 32'h8);
    do begin
      apb(0, `OFF_STAT, 0);
      k++;
    end while (rd[0] !== 1'b0 && k < 1000);
  endtask
  // ************************************
  // clock, reset, watchdog
  // ************************************
  initial begin
    clk = 0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    print_verdict;
  end
  // ************************************
  // tests
  // ************************************
  initial begin
    reset = 1;
    {psel, penable, pwrite, bad_bit} = '0;
    paddr = '0;
    pwdata = '0;
    thr = '0;
    odt_min = '0;
    oe_min = '0;
    err_total = 0;
    n_tests = 0;
    repeat (8) @(posedge clk);
    reset <= 0;
    apb(0, `OFF_STAT, 0);
    chk("stat reset", 0, rd);
    apb(0, `OFF_GAP, 0);
    chk("gap reset", 32'(`GAP_RST), rd);
    apb(0, 8'h14, 0);
    chk("unmapped err", 1, {31'h0, slv});
    // memory clock halves flip every CK_HALF cycles and stay complementary
    ck0 = ck_t;
    repeat (`CK_HALF_CYC) @(posedge clk);
    chk("ck toggle", {31'h0, !ck0}, {31'h0, ck_t});
    chk("ck pair", {31'h0, !ck_t}, {31'h0, ck_c});
    apb(1, `OFF_MR1, 32'h206);
    apb(1, `OFF_GAP, 32'h4);
    // lane one reads one from the start, so it never sees a rise
    run(0, 0, 0, {6'd0, 6'd2}, 0, 0);
    chk("stat overflow", 32'h106, rd);
    run(0, 0, 0, {6'd9, 6'd3}, 0, 0);
    chk("stat locked", 32'h302, rd);
    apb(0, `OFF_DLY, 0);
    chk("delay lanes", 32'h243, rd);
    chk("mr1 target", 32'h206, {18'h0, mr1[13:0]});
    chk("mr1 other", 32'h206, {18'h0, mr1[27:14]});
    // rank one, dll off, raised latency, skewed bit, write while busy
    run(1, 1, 1, {6'd1, 6'd1}, 1, 1);
    chk("stat mismatch", 32'h10302, rd);
    apb(0, `OFF_GAP, 0);
    chk("gap busy", 32'h4, rd);
    apb(0, `OFF_DLY, 0);
    chk("delay min", 32'h41, rd);
    chk("mr1 rank1", 32'h206, {18'h0, mr1[27:14]});
    chk("pin timing", 0, {24'h0, viol});
    print_verdict;
  end
endmodule

// file: test/wl_dram_model.sv
// dram model: mode register one per rank, leveling feedback, pin timing checks
`timescale 1ns/1ps
`include "wl_cfg.svh"
module wl_dram_model #(
  parameter int LANES = 2
) (
  input  wire logic               clk,
  input  wire logic               mrs_strobe,
  input  wire logic [1:0]         mrs_rank,
  input  wl_pkg::mr_value_t       mrs_value,
  input  wire logic               termination_control_pin,
  input  wire logic               dqs_t,
  input  wire logic               dqs_c,
  input  wire logic               dqs_oe,
  input  wire logic [LANES*6-1:0] dqs_delay,
  input  wire logic [LANES*6-1:0] thr,
  input  wire logic               bad_bit,
  input  wire logic [15:0]        odt_min,
  input  wire logic [15:0]        oe_min,
  output logic      [LANES*8-1:0] dq,
  output logic      [27:0]        mr1,
  output logic      [7:0]         viol
);
  import wl_pkg::*;
  // ************************************
  // state
  // ************************************
  logic lvl, got_fb, odt_p, oe_p, dqs_p;
  int   since, mgap, lo, hi, xgap;
  wire [13:0] cur = mrs_rank[0] ? mr1[27:14] : mr1[13:0];
  wire [13:0] oth = mrs_rank[0] ? mr1[13:0] : mr1[27:14];
  // strobes nominal with odt high, parked with it low; data pins never terminated
  wire [1:0] strobe_term = lvl ? (termination_control_pin ? 2'h1 : 2'h2) : 2'h0;
  // no read strobe output exists: feedback travels on dq alone
  initial begin
    dq = '0;
    mr1 = '0;
    viol = '0;
    lvl = 0;
    got_fb = 0;
    since = 0;
    mgap = 100;
    xgap = 1000;
    lo = 0;
    hi = 0;
  end
  // ************************************
  // commands, timing and feedback
  // ************************************
  always @(posedge clk) begin
    since <= since + 1;
    mgap <= mgap + 1;
    xgap <= xgap + 1;
    odt_p <= termination_control_pin;
    oe_p <= dqs_oe;
    dqs_p <= dqs_t;
    lo <= (dqs_t === 1'b1) ? 0 : lo + 1;
    hi <= (dqs_t === 1'b1) ? hi + 1 : 0;
    if (mrs_strobe) begin
      mgap <= 1;
      if (mgap < `T_MRD_CYC) viol <= viol + 1;
      // nothing may follow the exit write before the update delay
      if (xgap < `T_MOD_CYC) viol <= viol + 1;
      if (lvl && mrs_value[7] && ((mrs_value ^ cur) & 14'h2F7F) != 0) viol <= viol + 1;
      if (!lvl && mrs_value[7]) begin
        lvl <= 1;
        since <= 1;
        got_fb <= 0;
        if (mrs_value[12] || !oth[12]) viol <= viol + 1;
      end
      if (lvl && !mrs_value[7]) begin
        lvl <= 0;
        xgap <= 1;
        if (termination_control_pin || dqs_oe) viol <= viol + 1;
      end
      // whole word lands, so the exit may change other bits too
      if (mrs_rank[0]) mr1[27:14] <= mrs_value;
      else mr1[13:0] <= mrs_value;
    end
    if (termination_control_pin && !odt_p && (!lvl || since < odt_min)) viol <= viol + 1;
    if (dqs_oe && !oe_p && (!termination_control_pin || since <= oe_min)) viol <= viol + 1;
    if (dqs_oe && dqs_c === dqs_t) viol <= viol + 1;
    if (dqs_t && !dqs_p) begin
      if (!lvl || !dqs_oe || lo < `T_DQSL_CYC || (!got_fb && since < `T_WLMRD_CYC))
        viol <= viol + 1;
      got_fb <= 1;
      // flight skew stands in as a per-lane threshold on the delay setting
      for (int g = 0; g < LANES; g++)
        dq[g*8+:8] <= {8{dqs_delay[g*6+:6] >= thr[g*6+:6]}};
      if (bad_bit) dq[7] <= !(dqs_delay[5:0] >= thr[5:0]);
    end else if (!got_fb || !lvl) begin
      // undefined or released: keep it moving so no stale value passes
      dq <= ~dq;
    end
    if (!dqs_t && dqs_p && hi < `T_DQSH_CYC) viol <= viol + 1;
  end
endmodule
